// file: dcs_status_flags.sv
// Contract
// [RULE1] condition bit 7 reads 0 while a command runs, 1 when ready
// [RULE2] condition bit 6 reads 1 when the drive can accept a command
// [RULE3] condition bit 5 reads 1 after a write fault occurred
// [RULE4] condition bit 4 reads 1 when heads are settled over a track
// [RULE5] condition bit 3 reads 1 when the drive is ready to transfer data
// [RULE6] condition bit 2 reads 1 after a correctable data error was fixed
// [RULE7] condition bit 1 reads 1 while the index position is sensed
// [RULE8] condition bit 0 reads 1 when the last command ended in error
// [RULE9] fault bit 7 reads 1 when a bad block mark was detected
// [RULE10] fault bit 6 reads 1 when an uncorrectable data error was seen
// [RULE11] fault bit 4 reads 1 when the requested sector id was missing
// [RULE12] fault bit 2 reads 1 for an illegal command or drive status error
// [RULE13] fault bit 1 reads 1 when recalibrate could not find home track
// [RULE14] status word: condition byte first, fault byte second
// [RULE15] a full format covers 1400 cylinders, 16 heads, 63 sectors
// [RULE16] fault bits 5, 3, 0 read zero; writes to both registers ignored
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dcs_status_flags (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // controller core, same clock
  input  wire logic        cmd_start,
  input  wire logic        cmd_done,
  input  wire logic        xfer_ready,
  input  wire logic        fixed_evt,
  input  wire logic        bad_block_evt,
  input  wire logic        hard_data_evt,
  input  wire logic        id_missing_evt,
  input  wire logic        rejected_evt,
  input  wire logic        home_miss_evt,
  // drive pins, asynchronous
  input  wire logic        drive_accept_pin,
  input  wire logic        write_fault_pin,
  input  wire logic        seek_settled_pin,
  input  wire logic        index_pin
);

  // ****************************************************
  // reset release
  // ****************************************************

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       rst_n;

  // assert at once, release two edges later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ****************************************************
  // drive pin synchronisers
  // ****************************************************

  logic [dcs_pkg::NUM_PINS-1:0] pin_raw;
  logic [dcs_pkg::NUM_PINS-1:0] pin_meta_q;
  logic [dcs_pkg::NUM_PINS-1:0] pin_q;

  assign pin_raw[dcs_pkg::PIN_ACCEPT] = drive_accept_pin;
  assign pin_raw[dcs_pkg::PIN_WFAULT] = write_fault_pin;
  assign pin_raw[dcs_pkg::PIN_SETTLE] = seek_settled_pin;
  assign pin_raw[dcs_pkg::PIN_INDEX]  = index_pin;

  // two flops per pin; only the second stage is read
  genvar gi;
  generate
    for (gi = 0; gi < dcs_pkg::NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_meta_q[gi] <= 1'b0;
          pin_q[gi]      <= 1'b0;
        end else begin
          pin_meta_q[gi] <= pin_raw[gi];
          pin_q[gi]      <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************
  // apb decode
  // ****************************************************

  logic       setup_ph;
  logic       wr_acc;
  logic       hit_cond;
  logic       hit_fault;
  logic       hit_word;
  logic       hit_ctrl;
  logic       hit_any;
  logic       ctrl_wr;

  assign setup_ph  = psel & ~penable;
  assign wr_acc    = psel & penable & pwrite;
  assign hit_cond  = (paddr == dcs_pkg::OFS_COND);
  assign hit_fault = (paddr == dcs_pkg::OFS_FAULT);
  assign hit_word  = (paddr == dcs_pkg::OFS_WORD);
  assign hit_ctrl  = (paddr == dcs_pkg::OFS_CTRL);
  assign hit_any   = hit_cond | hit_fault | hit_word | hit_ctrl;
  // writes to the status registers fall through here
  assign ctrl_wr   = wr_acc & hit_ctrl & pstrb[0]; // [RULE16]

  // ****************************************************
  // control register
  // ****************************************************

  logic       auto_clr_q;
  logic       auto_clr_d;
  logic       clr_now;

  assign auto_clr_d = ctrl_wr ? pwdata[dcs_pkg::BIT_AUTO_CLR]
                              : auto_clr_q;
  // one-shot clear of the sticky flags, reads back zero
  assign clr_now = ctrl_wr & pwdata[dcs_pkg::BIT_CLR_NOW];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_clr_q <= dcs_pkg::CTRL_RESET[dcs_pkg::BIT_AUTO_CLR];
    end else begin
      auto_clr_q <= auto_clr_d;
    end
  end

  // ****************************************************
  // command tracking
  // ****************************************************

  dcs_pkg::dcs_cmd_state_t state_q;
  dcs_pkg::dcs_cmd_state_t state_d;

  // done beats start if both arrive together
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dcs_pkg::ST_READY: begin
        if (cmd_start && !cmd_done) begin
          state_d = dcs_pkg::ST_BUSY;
        end
      end
      dcs_pkg::ST_BUSY: begin
        if (cmd_done) begin
          state_d = dcs_pkg::ST_READY;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dcs_pkg::ST_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************
  // sticky flags
  // ****************************************************

  // index 0..5: bad block, hard data, id missing,
  // rejected, home miss, fixed data; 6: write fault
  localparam int NUM_STICKY = 7;

  logic [NUM_STICKY-1:0] stk_set;
  logic [NUM_STICKY-1:0] stk_q;
  logic [NUM_STICKY-1:0] stk_d;
  logic                  stk_clr;
  logic                  any_cause;
  logic                  cmd_err_q;
  logic                  cmd_err_d;
  logic                  cmd_err_set;

  assign stk_set[0] = bad_block_evt;                  // [RULE9]
  assign stk_set[1] = hard_data_evt;                  // [RULE10]
  assign stk_set[2] = id_missing_evt;                 // [RULE11]
  assign stk_set[3] = rejected_evt;                   // [RULE12]
  assign stk_set[4] = home_miss_evt;                  // [RULE13]
  assign stk_set[5] = fixed_evt;                      // [RULE6]
  assign stk_set[6] = pin_q[dcs_pkg::PIN_WFAULT];     // [RULE3]

  // a new command wipes the old causes unless software opted out
  assign stk_clr = clr_now | (cmd_start & auto_clr_q);

  // set wins over clear so no event is lost
  assign stk_d = stk_set | (stk_q & ~{NUM_STICKY{stk_clr}});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stk_q <= '0;
    end else begin
      stk_q <= stk_d;
    end
  end

  // error summary raised when a command finishes with a cause
  assign any_cause   = |stk_d[4:0];
  assign cmd_err_set = cmd_done & any_cause;          // [RULE8]
  assign cmd_err_d   = cmd_err_set | (cmd_err_q & ~stk_clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_err_q <= 1'b0;
    end else begin
      cmd_err_q <= cmd_err_d;
    end
  end

  // ****************************************************
  // register images
  // ****************************************************

  logic [7:0]  cond_img;
  logic [7:0]  fault_img;
  logic [15:0] word_img;
  logic [31:0] rd_mux;

  // occupied bit is inverted: zero means a command runs
  assign cond_img[dcs_pkg::BIT_OCCUPIED] =
    (state_q == dcs_pkg::ST_READY);                   // [RULE1]
  assign cond_img[dcs_pkg::BIT_ACCEPTING] =
    pin_q[dcs_pkg::PIN_ACCEPT];                       // [RULE2]
  assign cond_img[dcs_pkg::BIT_WR_FAULT]   = stk_q[6]; // [RULE3]
  assign cond_img[dcs_pkg::BIT_SETTLED] =
    pin_q[dcs_pkg::PIN_SETTLE];                       // [RULE4]
  assign cond_img[dcs_pkg::BIT_XFER_REQ]   = xfer_ready; // [RULE5]
  assign cond_img[dcs_pkg::BIT_FIXED_DATA] = stk_q[5]; // [RULE6]
  assign cond_img[dcs_pkg::BIT_INDEX] =
    pin_q[dcs_pkg::PIN_INDEX];                        // [RULE7]
  assign cond_img[dcs_pkg::BIT_CMD_ERROR]  = cmd_err_q; // [RULE8]

  // unused cause bits tie to zero
  always_comb begin
    fault_img = 8'h00;                                // [RULE16]
    fault_img[dcs_pkg::BIT_BAD_BLOCK]  = stk_q[0];    // [RULE9]
    fault_img[dcs_pkg::BIT_HARD_DATA]  = stk_q[1];    // [RULE10]
    fault_img[dcs_pkg::BIT_ID_MISSING] = stk_q[2];    // [RULE11]
    fault_img[dcs_pkg::BIT_REJECTED]   = stk_q[3];    // [RULE12]
    fault_img[dcs_pkg::BIT_HOME_MISS]  = stk_q[4];    // [RULE13]
  end

  // condition byte leads the pair
  assign word_img = {cond_img, fault_img};            // [RULE14]

  // read selection; unmapped reads zero
  assign rd_mux =
    hit_cond  ? {24'h000000, cond_img} :
    hit_fault ? {24'h000000, fault_img} :
    hit_word  ? {16'h0000, word_img} :
    hit_ctrl  ? {30'h00000000, 1'b0, auto_clr_q} :
                32'h00000000;

  // ****************************************************
  // apb answer
  // ****************************************************

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        slverr_q;
  logic        slverr_d;

  // sample in setup so data is stable through the access phase;
  // the trade is that a read shows the state one edge early
  assign prdata_d = (setup_ph && !pwrite) ? rd_mux : prdata_q;
  assign slverr_d = setup_ph ? ~hit_any : slverr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  // zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q & psel & penable;

endmodule

`default_nettype wire

// file: dcs_pkg.sv
// ****************************************************
// disk controller status flags: shared constants
// ****************************************************
package dcs_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_COND   = 8'h00;
  localparam logic [7:0] OFS_FAULT  = 8'h04;
  localparam logic [7:0] OFS_WORD   = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;

  // condition register bit positions
  localparam int BIT_OCCUPIED   = 7;
  localparam int BIT_ACCEPTING  = 6;
  localparam int BIT_WR_FAULT   = 5;
  localparam int BIT_SETTLED    = 4;
  localparam int BIT_XFER_REQ   = 3;
  localparam int BIT_FIXED_DATA = 2;
  localparam int BIT_INDEX      = 1;
  localparam int BIT_CMD_ERROR  = 0;

  // fault cause register bit positions
  localparam int BIT_BAD_BLOCK  = 7;
  localparam int BIT_HARD_DATA  = 6;
  localparam int BIT_ID_MISSING = 4;
  localparam int BIT_REJECTED   = 2;
  localparam int BIT_HOME_MISS  = 1;

  // status word: condition byte first (upper), fault byte second
  localparam int WORD_COND_LSB  = 8;
  localparam int WORD_FAULT_LSB = 0;

  // control register fields and reset value
  localparam int BIT_AUTO_CLR   = 0;
  localparam int BIT_CLR_NOW    = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // number of drive pins passed through synchronisers
  localparam int NUM_PINS = 4;
  localparam int PIN_ACCEPT = 0;
  localparam int PIN_WFAULT = 1;
  localparam int PIN_SETTLE = 2;
  localparam int PIN_INDEX  = 3;

  // drive geometry a full format must cover
  localparam int GEO_CYLINDERS = 1400;
  localparam int GEO_HEADS     = 16;
  localparam int GEO_SECTORS   = 63;
  localparam int GEO_SECT_BYTES = 512;

  // command tracking state
  typedef enum logic {
    ST_READY = 1'b0,
    ST_BUSY  = 1'b1
  } dcs_cmd_state_t;

endpackage

// file: dcs_status_flags_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// status flag checker
// ****************************************
module dcs_status_flags_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cmd_start,
  input wire logic        cmd_done,
  input wire logic        rejected_evt,
  input wire logic        xfer_ready,
  input wire logic        drive_accept_pin,
  input wire logic        seek_settled_pin,
  input wire logic        index_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read setup cycles; data lands on the edge after setup
  wire logic rd_s = psel && !penable && !pwrite;
  wire logic rd_c = rd_s && paddr == dcs_pkg::OFS_COND;
  wire logic rd_f = rd_s && paddr == dcs_pkg::OFS_FAULT;
  wire logic rd_w = rd_s && paddr == dcs_pkg::OFS_WORD;
  wire logic mapped = paddr[1:0] == 2'h0 && paddr <= dcs_pkg::OFS_CTRL;
  // access phase of a control write; it may wipe the sticky flags
  wire logic ctrl_w = psel && penable && pwrite && paddr == dcs_pkg::OFS_CTRL;
  // pin held three edges covers the two-flop sync delay
  property live_p(logic pin, logic flag);
    rd_c && $past(pin, 3) == pin && $past(pin, 2) == pin && $past(pin) == pin |=> flag == $past(pin);
  endproperty
  busy_bit_a: assert property (
    rd_c && $past(cmd_start, 2) && !$past(cmd_done, 2) && !$past(cmd_done)
    |=> !prdata[7]) else $error("busy bit not low");
  ready_bit_a: assert property (
    rd_c && $past(cmd_done, 2) && !$past(cmd_start, 2) && !$past(cmd_start)
    |=> prdata[7]) else $error("ready bit not high");
  accept_live_a: assert property (live_p(drive_accept_pin, prdata[6])) else $error("accept bit wrong");
  settle_live_a: assert property (live_p(seek_settled_pin, prdata[4])) else $error("settle bit wrong");
  xfer_live_a: assert property (live_p(xfer_ready, prdata[3])) else $error("xfer bit wrong");
  index_live_a: assert property (live_p(index_pin, prdata[1])) else $error("index bit wrong");
  // a clear in the cycle before the setup edge would wipe the flag legally
  cmd_err_a: assert property (
    rd_c && $past(cmd_done, 2) && $past(rejected_evt, 2) && !$past(cmd_start) && !$past(ctrl_w)
    |=> prdata[0]) else $error("error bit not set");
  reject_set_a: assert property (
    rd_f && $past(rejected_evt, 2) && !$past(cmd_start) && !$past(ctrl_w)
    |=> prdata[2]) else $error("reject bit not set");
  word_layout_a: assert property (
    rd_w && $past(rejected_evt, 2) && !$past(cmd_start) && !$past(ctrl_w)
    |=> prdata[2] && prdata[31:16] == 16'h0) else $error("status word layout wrong");
  unused_zero_a: assert property (
    rd_f |=> prdata[31:8] == 24'h0 && !prdata[5] && !prdata[3] && !prdata[0])
    else $error("unused fault bits set");
  slverr_map_a: assert property (psel && penable |-> pready && pslverr == !mapped) else $error("bad response");
  unmapped_zero_a: assert property (rd_s && !mapped |=> prdata == 32'h0) else $error("unmapped data not zero");
  err_seen_c: cover property (rd_c ##1 prdata[0]);
  refused_c: cover property (psel && penable && pslverr);
  word_read_c: cover property (rd_w);
endmodule

bind dcs_status_flags dcs_status_flags_chk i_chk (
  .clk              (clk),
  .rst_b            (rst_b),
  .psel             (psel),
  .penable          (penable),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .prdata           (prdata),
  .pready           (pready),
  .pslverr          (pslverr),
  .cmd_start        (cmd_start),
  .cmd_done         (cmd_done),
  .rejected_evt     (rejected_evt),
  .xfer_ready       (xfer_ready),
  .drive_accept_pin (drive_accept_pin),
  .seek_settled_pin (seek_settled_pin),
  .index_pin        (index_pin)
);
`default_nettype wire

// file: dcs_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// drive pin model
// ****************************************
module dcs_drive_model (
  input  wire logic       clk,
  input  wire logic [3:0] lvl,
  output logic            drive_accept_pin,
  output logic            write_fault_pin,
  output logic            seek_settled_pin,
  output logic            index_pin
);
  logic [3:0] pins_q = 4'h0;
  // lines move just after an edge, so the sync sees a clean level
  always_ff @(posedge clk) begin
    pins_q <= lvl;
  end
  // pin order follows the package pin indices
  assign drive_accept_pin = pins_q[dcs_pkg::PIN_ACCEPT];
  assign write_fault_pin  = pins_q[dcs_pkg::PIN_WFAULT];
  assign seek_settled_pin = pins_q[dcs_pkg::PIN_SETTLE];
  assign index_pin        = pins_q[dcs_pkg::PIN_INDEX];
endmodule
`default_nettype wire

// file: tb_disk_controller_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// status flag bench
// ****************************************
module tb_disk_controller_status_flags;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xfer_ready = 1'b0;
  logic [7:0]  ev = 8'h00; // bit5 start, bit3 done, bit0 fixed, rest fault causes
  logic [3:0]  lvl = 4'h0;
  logic        p_acc, p_wf, p_set, p_idx;
  int          num_errors = 0;
  int          samples_checked = 0;
  always #10 clk = ~clk;
  dcs_drive_model i_drv (.clk(clk), .lvl(lvl), .drive_accept_pin(p_acc), .write_fault_pin(p_wf),
    .seek_settled_pin(p_set), .index_pin(p_idx));
  dcs_status_flags i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_start(ev[5]), .cmd_done(ev[3]), .xfer_ready(xfer_ready), .fixed_evt(ev[0]),
    .bad_block_evt(ev[7]), .hard_data_evt(ev[6]), .id_missing_evt(ev[4]), .rejected_evt(ev[2]),
    .home_miss_evt(ev[1]), .drive_accept_pin(p_acc), .write_fault_pin(p_wf),
    .seek_settled_pin(p_set), .index_pin(p_idx));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; the wait on pready is bounded
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
    if (!w) chk("prdata", exp, prdata);
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one-cycle pulse on the core event inputs
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    acc(0, dcs_pkg::OFS_COND, 0, 32'h80, 0);
    acc(0, dcs_pkg::OFS_FAULT, 0, 32'h0, 0);
    acc(0, dcs_pkg::OFS_CTRL, 0, {30'h0, dcs_pkg::CTRL_RESET}, 0);
    chk("format sectors", 32'h00158880, dcs_pkg::GEO_CYLINDERS * dcs_pkg::GEO_HEADS * dcs_pkg::GEO_SECTORS);
    $display("test reset values done");
    lvl <= 4'hF;
    xfer_ready <= 1'b1;
    repeat (5) @(posedge clk);
    acc(0, dcs_pkg::OFS_COND, 0, 32'hFA, 0);
    lvl <= 4'h0;
    xfer_ready <= 1'b0;
    repeat (5) @(posedge clk);
    acc(0, dcs_pkg::OFS_COND, 0, 32'hA0, 0);
    $display("test drive levels done");
    pulse(8'h20);
    acc(0, dcs_pkg::OFS_COND, 0, 32'h00, 0);
    pulse(8'hDF);
    acc(0, dcs_pkg::OFS_COND, 0, 32'h85, 0);
    pulse(8'h04);
    acc(0, dcs_pkg::OFS_FAULT, 0, 32'hD6, 0);
    pulse(8'h04);
    acc(0, dcs_pkg::OFS_WORD, 0, 32'h85D6, 0);
    $display("test failed command done");
    acc(1, dcs_pkg::OFS_COND, 32'hFFFFFFFF, 0, 0);
    acc(1, dcs_pkg::OFS_FAULT, 32'h0, 0, 0);
    acc(0, dcs_pkg::OFS_WORD, 0, 32'h85D6, 0);
    acc(0, 8'h40, 0, 32'h0, 1);
    acc(1, 8'h10, 32'hFFFFFFFF, 0, 1);
    acc(1, dcs_pkg::OFS_CTRL, 32'h2, 0, 0);
    acc(0, dcs_pkg::OFS_CTRL, 0, 32'h0, 0);
    acc(0, dcs_pkg::OFS_WORD, 0, 32'h8000, 0);
    pulse(8'h20);
    pulse(8'h09);
    acc(0, dcs_pkg::OFS_COND, 0, 32'h84, 0);
    // auto clear is off: a cause raised before the start must survive it
    pulse(8'h04);
    pulse(8'h20);
    pulse(8'h08);
    acc(0, dcs_pkg::OFS_WORD, 0, 32'h8504, 0);
    $display("test refusals and clean command done");
    complete_run();
  end
endmodule
`default_nettype wire
